//--- src/spis_consts.vh
// constants of the serial slave: register offsets, field positions, reset values
// assumes inclusion by bare name from the design files under src/
// What this block does
// - receive ready may rise falsely around enable
// - disable command ignored while in slave mode
// - transmit writes discarded while disabled
// - disable leaves transmit empty flag untouched
// - dma writes after disable are lost
`ifndef SPIS_CONSTS_VH
`define SPIS_CONSTS_VH
// ******************************
// register offsets
// ******************************
`define SPIS_AW 5
`define SPIS_OFS_CMD 5'h00
`define SPIS_OFS_MODE 5'h04
`define SPIS_OFS_STAT 5'h08
`define SPIS_OFS_RXD 5'h0C
`define SPIS_OFS_TXD 5'h10
`define SPIS_OFS_IMASK 5'h14
`define SPIS_OFS_ISTAT 5'h18
// ******************************
// field positions
// ******************************
`define SPIS_CMD_EN 0
`define SPIS_CMD_DIS 1
`define SPIS_CMD_SWRST 2
`define SPIS_MODE_SLAVE 0
`define SPIS_MODE_CLOCK_POLARITY 1
`define SPIS_MODE_CLOCK_PHASE 2
`define SPIS_ST_RXRDY 0
`define SPIS_ST_TXE 1
`define SPIS_ST_OVR 2
`define SPIS_ST_EN 3
// interrupt bits share the status layout of the first three
`define SPIS_IRQ_W 3
`define SPIS_MODE_W 3
// ******************************
// reset values
// ******************************
`define SPIS_MODE_RST 3'h0
`define SPIS_TXE_RST 1'h1
`define SPIS_IRQ_RST 3'h0
`endif

//--- src/spis_sync.v
// three-stage synchroniser for pin inputs, accepted when stages two and three agree
// assumes a single clock core_clk and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module spis_sync #(
  parameter W = 3,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  // chain plus agreement filter, first stage feeds only the second
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_out <= (s2_r & ~(s2_r ^ s3_r)) | (q_out & (s2_r ^ s3_r));
    end
  end
endmodule // spis_sync
`default_nettype wire

//--- src/spis_top.v
// serial peripheral slave with enable, disable, flags, dma handshake and interrupt
// assumes core_clk at 100 MHz; link pins asynchronous; register port read data one cycle later
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spis_consts.vh"
module spis_top #(
  parameter DW = 8
) (
  input wire core_clk,
  input wire rst_b,
  input wire [`SPIS_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire sck_in,
  input wire mosi_in,
  input wire ss_b_in,
  output reg miso_out,
  output reg miso_oe,
  input wire dma_wr,
  input wire [DW-1:0] dma_wdata,
  output reg dma_tx_req,
  output reg irq
);
  // ******************************
  // pin synchronisation
  // ******************************
  wire [2:0] pins_s;
  // reset to idle levels: select high, clock and data low, so no false edge
  spis_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .d_in({ss_b_in, mosi_in, sck_in}),
    .q_out(pins_s)
  );
  wire sck_s = pins_s[0];
  wire mosi_s = pins_s[1];
  wire ss_act = ~pins_s[2];

  // ******************************
  // state
  // ******************************
  reg en_r;
  reg [`SPIS_MODE_W-1:0] mode_r;
  reg rx_rdy_r;
  reg tx_empty_r;
  reg ovr_r;
  reg [DW-1:0] tdr_r;
  reg [DW-1:0] rhr_r;
  reg [DW-1:0] sh_rx_r;
  reg [DW-1:0] sh_tx_r;
  reg [3:0] cnt_r;
  reg ld_r;
  reg ok_r;
  reg eclk_prev_r;
  reg [`SPIS_IRQ_W-1:0] ist_r;
  reg [`SPIS_IRQ_W-1:0] imask_r;

  wire slave = mode_r[`SPIS_MODE_SLAVE];
  wire clock_polarity = mode_r[`SPIS_MODE_CLOCK_POLARITY];
  wire clock_phase = mode_r[`SPIS_MODE_CLOCK_PHASE];

  // register strobe decode
  function hit;
    input [`SPIS_AW-1:0] a;
    input [`SPIS_AW-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_cmd = reg_wr && hit(reg_addr, `SPIS_OFS_CMD);
  wire swrst = wr_cmd && reg_wdata[`SPIS_CMD_SWRST];
  wire rd_rxd = reg_rd && hit(reg_addr, `SPIS_OFS_RXD);
  // cpu or dma write to the transmit data register
  wire tx_wr = (reg_wr && hit(reg_addr, `SPIS_OFS_TXD)) || dma_wr;
  wire [DW-1:0] tx_wdata = dma_wr ? dma_wdata : reg_wdata[DW-1:0];
  wire tx_take = tx_wr && en_r;

  // polarity folded clock; a polarity flip while enabled and selected in slave mode looks like an edge
  wire eclk = sck_s ^ clock_polarity;
  wire run = en_r && slave && ss_act;
  wire lead = run && eclk && !eclk_prev_r;
  wire trail = run && !eclk && eclk_prev_r;
  wire smp = clock_phase ? trail : lead;
  wire shf = clock_phase ? lead : trail;
  wire word_done = smp && (cnt_r == DW - 1);
  wire load = run && !ld_r;

  // ******************************
  // enable, mode and shift engine
  // ******************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
      mode_r <= `SPIS_MODE_RST;
      tdr_r <= {DW{1'b0}};
      rhr_r <= {DW{1'b0}};
      sh_rx_r <= {DW{1'b0}};
      sh_tx_r <= {DW{1'b0}};
      cnt_r <= 4'h0;
      ld_r <= 1'b0;
      ok_r <= 1'b0;
      eclk_prev_r <= 1'b0;
      rx_rdy_r <= 1'b0;
      tx_empty_r <= `SPIS_TXE_RST;
      ovr_r <= 1'b0;
    end else if (swrst) begin
      // back to disabled, flags and buffers cleared in any mode
      en_r <= 1'b0;
      tdr_r <= {DW{1'b0}};
      rhr_r <= {DW{1'b0}};
      sh_rx_r <= {DW{1'b0}};
      sh_tx_r <= {DW{1'b0}};
      cnt_r <= 4'h0;
      ld_r <= 1'b0;
      ok_r <= 1'b0;
      eclk_prev_r <= eclk;
      rx_rdy_r <= 1'b0;
      tx_empty_r <= `SPIS_TXE_RST;
      ovr_r <= 1'b0;
    end else begin
      eclk_prev_r <= eclk;
      if (wr_cmd && reg_wdata[`SPIS_CMD_EN])
        en_r <= 1'b1;
      else if (wr_cmd && reg_wdata[`SPIS_CMD_DIS] && !slave)
        en_r <= 1'b0; // slave ignores disable
      if (reg_wr && hit(reg_addr, `SPIS_OFS_MODE))
        mode_r <= reg_wdata[`SPIS_MODE_W-1:0];
      // disable never touches the empty flag; only accepted writes clear it
      if (load) begin
        sh_tx_r <= tx_empty_r ? {DW{1'b0}} : tdr_r;
        ld_r <= 1'b1;
        ok_r <= 1'b0;
        tx_empty_r <= 1'b1;
        // a write in the load cycle refills the buffer instead of being lost
        if (tx_take) begin
          tdr_r <= tx_wdata;
          tx_empty_r <= 1'b0;
        end
      end else if (tx_take) begin
        tdr_r <= tx_wdata;
        tx_empty_r <= 1'b0;
      end
      if (!ss_act) begin
        cnt_r <= 4'h0;
        ld_r <= 1'b0;
      end
      // counter kept across enable, so a stale partial word can flag ready
      if (smp) begin
        sh_rx_r <= {sh_rx_r[DW-2:0], mosi_s};
        ok_r <= 1'b1;
        cnt_r <= cnt_r + 4'h1;
        if (word_done) begin
          rhr_r <= {sh_rx_r[DW-2:0], mosi_s};
          cnt_r <= 4'h0;
          ld_r <= 1'b0;
          ok_r <= 1'b0;
        end
      end
      if (shf && ok_r)
        sh_tx_r <= {sh_tx_r[DW-2:0], 1'b0};
      // new word wins over the clearing read
      if (word_done) begin
        rx_rdy_r <= 1'b1;
        if (rx_rdy_r && !rd_rxd)
          ovr_r <= 1'b1;
      end else if (rd_rxd) begin
        rx_rdy_r <= 1'b0;
      end
      if (reg_rd && hit(reg_addr, `SPIS_OFS_STAT) && !(word_done && rx_rdy_r))
        ovr_r <= 1'b0;
    end
  end

  // ******************************
  // interrupt status and mask
  // ******************************
  wire [`SPIS_IRQ_W-1:0] ev;
  assign ev[`SPIS_ST_RXRDY] = word_done;
  assign ev[`SPIS_ST_TXE] = load && !tx_empty_r;
  assign ev[`SPIS_ST_OVR] = word_done && rx_rdy_r && !rd_rxd;
  wire wr_ist = reg_wr && hit(reg_addr, `SPIS_OFS_ISTAT);

  // sticky bits, set beats write-one clear
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ist_r <= `SPIS_IRQ_RST;
      imask_r <= `SPIS_IRQ_RST;
    end else if (swrst) begin
      ist_r <= `SPIS_IRQ_RST;
    end else begin
      ist_r <= ev | (ist_r & ~(wr_ist ? reg_wdata[`SPIS_IRQ_W-1:0] : `SPIS_IRQ_RST));
      if (reg_wr && hit(reg_addr, `SPIS_OFS_IMASK))
        imask_r <= reg_wdata[`SPIS_IRQ_W-1:0];
    end
  end

  // ******************************
  // read data and registered outputs
  // ******************************
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0;
    case (reg_addr)
      `SPIS_OFS_MODE: rd_nxt[`SPIS_MODE_W-1:0] = mode_r;
      `SPIS_OFS_STAT: begin
        rd_nxt[`SPIS_ST_RXRDY] = rx_rdy_r;
        rd_nxt[`SPIS_ST_TXE] = tx_empty_r;
        rd_nxt[`SPIS_ST_OVR] = ovr_r;
        rd_nxt[`SPIS_ST_EN] = en_r;
      end
      `SPIS_OFS_RXD: rd_nxt[DW-1:0] = rhr_r;
      `SPIS_OFS_IMASK: rd_nxt[`SPIS_IRQ_W-1:0] = imask_r;
      `SPIS_OFS_ISTAT: rd_nxt[`SPIS_IRQ_W-1:0] = ist_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  // every output from a flip-flop
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      dma_tx_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : 32'h0;
      miso_out <= sh_tx_r[DW-1];
      miso_oe <= run;
      dma_tx_req <= tx_empty_r && !swrst; // follows the empty flag, held while disabled, low for one cycle after a soft reset
      irq <= |(ist_r & imask_r);
    end
  end
endmodule // spis_top
`default_nettype wire

//--- sim/spis_chk_sva.sv
// checker of the serial slave top ports
// assumes bind from tb, clock core_clk, reset rst_b
`timescale 1ns/1ps
`default_nettype none
module spis_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dma_wr,
  input wire logic dma_tx_req,
  input wire logic irq
);
  logic en_r;
  logic slv_r;
  wire cmd = reg_wr && reg_addr == 5'h00;
  wire swr = cmd && reg_wdata[2];
  // enable state as the commands should leave it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
      slv_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 5'h04)
        slv_r <= reg_wdata[0];
      if (swr)
        en_r <= 1'b0;
      else if (cmd && reg_wdata[0])
        en_r <= 1'b1;
      else if (cmd && reg_wdata[1] && !slv_r)
        en_r <= 1'b0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_txe_back;
    !dma_tx_req ##1 dma_tx_req;
  endsequence
  property p_swr_txe;
    swr |=> s_txe_back;
  endproperty
  a_swr_txe: assert property (p_swr_txe) else $error("empty flag not back");
  property p_swr_irq;
    swr |-> ##2 !irq;
  endproperty
  a_swr_irq: assert property (p_swr_irq) else $error("irq after reset");
  property p_stat_en;
    reg_rd && reg_addr == 5'h08 |=> reg_rdata[3] == en_r;
  endproperty
  a_stat_en: assert property (p_stat_en) else $error("enable bit wrong");
  property p_dis_txe;
    dma_tx_req && !en_r && !swr |=> dma_tx_req;
  endproperty
  a_dis_txe: assert property (p_dis_txe) else $error("empty flag fell");
  property p_dma_drop;
    dma_wr && !en_r && !swr ##1 !swr |=> $stable(dma_tx_req);
  endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("dma word taken");
  property p_cpu_drop;
    reg_wr && reg_addr == 5'h10 && !en_r ##1 !swr |=> $stable(dma_tx_req);
  endproperty
  a_cpu_drop: assert property (p_cpu_drop) else $error("cpu word taken");
endmodule // spis_chk
`default_nettype wire

//--- sim/spis_mst.sv
// model of the external master on the link pins
// assumes any polarity and phase, 80 ns link period
`timescale 1ns/1ps
`default_nettype none
module spis_mst (
  output logic sck,
  output logic mosi,
  output logic ss_b,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_b = 1'b1;
  end
  // one frame msb first, clock still between frames
  // idle level set well before select so no edge meets an active select
  task xfer(input logic pol, input logic ph, input logic [7:0] d, output logic [7:0] q);
    sck = pol;
    #100 ss_b = 1'b0;
    #203;
    for (int i = 7; i >= 0; i--) begin
      if (ph) begin
        sck = ~pol;
        mosi = d[i];
        #40 sck = pol;
        #39 q[i] = miso;
        #1;
      end else begin
        mosi = d[i];
        #40 sck = ~pol;
        #39 q[i] = miso;
        #1 sck = pol;
      end
    end
    #40 ss_b = 1'b1;
    mosi = ~mosi; // released line shows inverse
    #200;
  endtask
endmodule // spis_mst
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the serial slave
// assumes spis_top, spis_mst and spis_chk
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst_b, reg_wr, reg_rd, dma_wr;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [7:0] dma_wdata, q;
  wire [31:0] reg_rdata;
  wire miso_out, miso_oe, dma_tx_req, irq, sck, mosi, ss_b;
  wire miso = miso_oe ? miso_out : ~miso_out; // released line shows inverse
  int n_errors, n_checks;
  spis_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_in(sck), .mosi_in(mosi), .ss_b_in(ss_b), .miso_out(miso_out), .miso_oe(miso_oe),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_tx_req(dma_tx_req), .irq(irq));
  spis_mst u_mst (.sck(sck), .mosi(mosi), .ss_b(ss_b), .miso(miso));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read, compare unless expected is unknown
  task rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    if (^e !== 1'bx)
      chk(reg_rdata, e);
  endtask
  // request copy shows a taken word one cycle after the taking edge
  task dma(input logic [7:0] d, input logic e);
    @(posedge core_clk);
    dma_wr <= 1'b1;
    dma_wdata <= d;
    @(posedge core_clk);
    dma_wr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(dma_tx_req, e);
  endtask
  task t_start;
    wr(5'h14, 32'h3);
    wr(5'h04, 32'h1);
    wr(5'h00, 32'h1);
    wr(5'h04, 32'h3);
    wr(5'h04, 32'h1);
    rdc(5'h0C, 32'hX);
    rdc(5'h08, 32'hA);
    wr(5'h18, 32'h7);
    wr(5'h10, 32'hA5);
    u_mst.xfer(1'b0, 1'b0, 8'h3C, q);
    chk(q, 8'hA5);
    rdc(5'h18, 32'h3);
    chk(irq, 1'b1);
    rdc(5'h0C, 32'h3C);
    wr(5'h18, 32'h7);
    rdc(5'h18, 32'h0);
    chk(irq, 1'b0);
    $display("start done");
  endtask
  task t_slv_dis;
    wr(5'h00, 32'h2);
    rdc(5'h08, 32'hA);
    wr(5'h10, 32'h5A);
    u_mst.xfer(1'b0, 1'b0, 8'hC3, q);
    chk(q, 8'h5A);
    rdc(5'h0C, 32'hC3);
    wr(5'h00, 32'h4);
    rdc(5'h08, 32'h2);
    rdc(5'h18, 32'h0);
    chk(irq, 1'b0);
    rdc(5'h1C, 32'h0);
    $display("slave disable done");
  endtask
  task t_dma;
    wr(5'h04, 32'h0);
    wr(5'h00, 32'h1);
    wr(5'h00, 32'h2);
    rdc(5'h08, 32'h2);
    repeat (3) dma(8'h77, 1'b1);
    wr(5'h10, 32'h66);
    rdc(5'h08, 32'h2);
    rdc(5'h18, 32'h0);
    wr(5'h04, 32'h1);
    wr(5'h00, 32'h1);
    u_mst.xfer(1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    wr(5'h00, 32'h4);
    $display("dma disable done");
  endtask
  // orderly pause: dma idle, then disable; resume interface before dma
  task t_pause;
    wr(5'h04, 32'h0);
    wr(5'h00, 32'h1);
    dma(8'h3A, 1'b0);
    repeat (2) @(posedge core_clk);
    wr(5'h00, 32'h2);
    rdc(5'h08, 32'h0);
    wr(5'h04, 32'h1);
    wr(5'h00, 32'h1);
    u_mst.xfer(1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h3A);
    dma(8'h4B, 1'b0);
    rdc(5'h0C, 32'h0);
    wr(5'h00, 32'h4);
    $display("dma pause done");
  endtask
  // inverted clock and late phase, after the start-up sequence
  task t_modes;
    wr(5'h04, 32'h7);
    wr(5'h00, 32'h1);
    wr(5'h04, 32'h5);
    wr(5'h04, 32'h7);
    rdc(5'h0C, 32'hX);
    wr(5'h10, 32'hC6);
    u_mst.xfer(1'b1, 1'b1, 8'h96, q);
    chk(q, 8'hC6);
    rdc(5'h08, 32'hB);
    rdc(5'h0C, 32'h96);
    wr(5'h00, 32'h4);
    $display("phase and polarity done");
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, dma_wr, reg_addr, reg_wdata, dma_wdata} = '0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_start;
    t_slv_dis;
    t_dma;
    t_pause;
    t_modes;
    test_done;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule // tb
bind spis_top spis_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dma_wr(dma_wr), .dma_tx_req(dma_tx_req), .irq(irq));
`default_nettype wire
